/* common/dcfifo_map.vh */
`ifndef DCFIFO_MAP_VH
`define DCFIFO_MAP_VH

// Word width of both data ports
`define DCFIFO_DATA_WIDTH 9
// Default depth in words and its pointer width
`define DCFIFO_DEPTH      1024
`define DCFIFO_ADDR_WIDTH 10

// Offsets after reset: empty plus seven, full minus seven
`define DCFIFO_AE_DEFAULT 7
`define DCFIFO_AF_DEFAULT 7

// Offset values are moved in slices of one data word
`define DCFIFO_OFF_SLICE  9
`define DCFIFO_OFF_WIDTH  18

// Offset access sequence steps (2-bit counter)
`define DCFIFO_STEP_AE_LO 2'h0
`define DCFIFO_STEP_AE_HI 2'h1
`define DCFIFO_STEP_AF_LO 2'h2
`define DCFIFO_STEP_AF_HI 2'h3

`endif

/* hw/dcfifo_ram.v */
`timescale 1ns/1ps
`include "dcfifo_map.vh"

// Storage array: one clocked write port, one combinational read port
module dcfifo_ram #(
  parameter WIDTH = `DCFIFO_DATA_WIDTH,
  parameter DEPTH = `DCFIFO_DEPTH,
  parameter AW    = `DCFIFO_ADDR_WIDTH
) (
  // Clock
  input  wire             mclk,
  // Write port
  input  wire             writeEn,
  input  wire [AW-1:0]    writeAddr,
  input  wire [WIDTH-1:0] writeWord,
  // Read port
  input  wire [AW-1:0]    readAddr,
  output wire [WIDTH-1:0] readWord
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // No reset on the array; contents are only visible after a write
  always @(posedge mclk)
  begin
    if (writeEn)
    begin
      mem[writeAddr] <= writeWord;
    end
  end

  // Asynchronous read, registered by the caller
  assign readWord = mem[readAddr];

endmodule // dcfifo_ram

/* hw/dcfifo_top.v */
`timescale 1ns/1ps
`include "dcfifo_map.vh"

module dcfifo_top #(
  parameter WIDTH = `DCFIFO_DATA_WIDTH,
  parameter DEPTH = `DCFIFO_DEPTH,
  parameter AW    = `DCFIFO_ADDR_WIDTH
) (
  // System clock and reset
  input  wire             mclk,
  input  wire             reset,
  // Master reset pin, active low
  input  wire             masterResetN,
  // Write port, sampled on mclk
  input  wire             writeClock,
  input  wire             primaryWriteEnableN,
  input  wire             secondWriteEnableOrLoad,
  input  wire [WIDTH-1:0] writeData,
  // Read port, sampled on mclk except the output enable, which is combinational
  input  wire             readClock,
  input  wire             readEnableAN,
  input  wire             readEnableBN,
  input  wire             outputEnableN,
  output wire [WIDTH-1:0] readData,
  output wire             readDataOe,
  // Status flags, all active low
  output wire             emptyFlagN,
  output wire             fullFlagN,
  output wire             almostEmptyFlagN,
  output wire             almostFullFlagN
);

  // Count width holds 0..DEPTH inclusive
  localparam [AW:0] FULL_COUNT = DEPTH;
  localparam        OW         = `DCFIFO_OFF_WIDTH;
  localparam        SL         = `DCFIFO_OFF_SLICE;
  // A depth above one slice needs two slices per offset value
  localparam        TWO_SLICES = (AW > SL) ? 1 : 0;
  localparam [OW-1:0] OFF_MASK  = (DEPTH - 1);
  localparam [OW-1:0] AE_RESET  = `DCFIFO_AE_DEFAULT;
  localparam [OW-1:0] AF_RESET  = `DCFIFO_AF_DEFAULT;

  // Edge detectors for the port clocks
  reg               writeClockPrev_r;
  reg               readClockPrev_r;
  // Mode caught at reset
  reg               modeCatch_r;
  reg               twoEnableMode_r;
  // Pointers carry one extra wrap bit
  reg  [AW:0]       writePtr_r;
  reg  [AW:0]       readPtr_r;
  // Flags
  reg               emptyFlagN_r;
  reg               fullFlagN_r;
  reg               almostEmptyFlagN_r;
  reg               almostFullFlagN_r;
  // Offset register and its access sequence
  reg  [OW-1:0]     aeOffset_r;
  reg  [OW-1:0]     afOffset_r;
  reg  [1:0]        loadStep_r;
  reg  [1:0]        readStep_r;
  // Output word
  reg  [WIDTH-1:0]  readData_r;

  wire              writeEdge;
  wire              readEdge;
  wire              loadMode;
  wire              bufWrite;
  wire              bufRead;
  wire              offLoad;
  wire              offRead;
  wire [AW:0]       countNow;
  wire [AW:0]       countNext;
  wire [AW:0]       freeNext;
  wire [AW:0]       aeLimit;
  wire [AW:0]       afLimit;
  wire [WIDTH-1:0]  ramWord;
  wire [1:0]        loadStepNxt;
  wire [1:0]        readStepNxt;
  reg  [WIDTH-1:0]  offSlice;
  reg  [OW-1:0]     loadMerged;

  // Port clocks are plain inputs here; a rising edge is one mclk cycle
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      writeClockPrev_r <= 1'b0;
      readClockPrev_r  <= 1'b0;
    end
    else
    begin
      writeClockPrev_r <= writeClock;
      readClockPrev_r  <= readClock;
    end
  end

  assign writeEdge = writeClock & ~writeClockPrev_r;
  assign readEdge  = readClock & ~readClockPrev_r;

  // The pin is caught by a clocked process, never by the async reset itself
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      modeCatch_r     <= 1'b1;
      twoEnableMode_r <= 1'b1;
    end
    else
    begin
      if (!masterResetN || modeCatch_r)
      begin
        twoEnableMode_r <= secondWriteEnableOrLoad;
      end
      modeCatch_r <= ~masterResetN;
    end
  end

  // Offset mode with the pin low turns both clocks toward the offset register
  assign loadMode = ~twoEnableMode_r & ~secondWriteEnableOrLoad;

  // The same buffer write term serves both modes: in offset mode the pin is high
  // whenever load is not asserted, so enable one is the only write enable
  assign bufWrite = writeEdge & ~primaryWriteEnableN & secondWriteEnableOrLoad
                    & fullFlagN_r & ~modeCatch_r;
  assign offLoad  = writeEdge & ~primaryWriteEnableN & loadMode & ~modeCatch_r;
  assign bufRead  = readEdge & ~readEnableAN & ~readEnableBN & ~loadMode
                    & emptyFlagN_r & ~modeCatch_r;
  assign offRead  = readEdge & ~readEnableAN & ~readEnableBN & loadMode
                    & ~modeCatch_r;

  // Both ports run on mclk, so pointers are compared directly with no crossing;
  // tied or independent port clocks only change which edges arrive
  assign countNow  = writePtr_r - readPtr_r;
  assign countNext = countNow + {{AW{1'b0}}, bufWrite} - {{AW{1'b0}}, bufRead};
  assign freeNext  = FULL_COUNT - countNext;
  assign aeLimit   = aeOffset_r[AW:0];
  assign afLimit   = afOffset_r[AW:0];

  // Storage, one word per location, all data bits kept
  dcfifo_ram #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_ram (
    .mclk      (mclk),
    .writeEn   (bufWrite),
    .writeAddr (writePtr_r[AW-1:0]),
    .writeWord (writeData),
    .readAddr  (readPtr_r[AW-1:0]),
    .readWord  (ramWord)
  );

  // Pointer update; master reset empties the buffer
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      writePtr_r <= {(AW+1){1'b0}};
      readPtr_r  <= {(AW+1){1'b0}};
    end
    else if (!masterResetN)
    begin
      writePtr_r <= {(AW+1){1'b0}};
      readPtr_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (bufWrite)
      begin
        writePtr_r <= writePtr_r + {{AW{1'b0}}, 1'b1};
      end
      if (bufRead)
      begin
        readPtr_r <= readPtr_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // Read-side flags move only on read edges or a reset and hold until the next one
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      emptyFlagN_r       <= 1'b0;
      almostEmptyFlagN_r <= 1'b0;
    end
    else if (!masterResetN)
    begin
      emptyFlagN_r       <= 1'b0;
      almostEmptyFlagN_r <= 1'b0;
    end
    else if (readEdge)
    begin
      emptyFlagN_r       <= (countNext != {(AW+1){1'b0}});
      almostEmptyFlagN_r <= (countNext > aeLimit);
    end
  end

  // Write-side flags move only on write edges or a reset; a stale full flag is only
  // conservative because reads can never make the buffer fuller
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      fullFlagN_r       <= 1'b1;
      almostFullFlagN_r <= 1'b1;
    end
    else if (!masterResetN)
    begin
      fullFlagN_r       <= 1'b1;
      almostFullFlagN_r <= 1'b1;
    end
    else if (writeEdge)
    begin
      fullFlagN_r       <= (countNext != FULL_COUNT);
      almostFullFlagN_r <= (freeNext > afLimit);
    end
  end

  // Steps skip the high slice when one slice covers the depth
  assign loadStepNxt = (TWO_SLICES != 0) ? loadStep_r + 2'h1 : loadStep_r + 2'h2;
  assign readStepNxt = (TWO_SLICES != 0) ? readStep_r + 2'h1 : readStep_r + 2'h2;

  // Merge one incoming slice into the addressed offset value
  always @*
  begin
    loadMerged = {OW{1'b0}};
    case (loadStep_r)
      `DCFIFO_STEP_AE_LO: loadMerged = {aeOffset_r[OW-1:SL], writeData};
      `DCFIFO_STEP_AE_HI: loadMerged = {writeData, aeOffset_r[SL-1:0]};
      `DCFIFO_STEP_AF_LO: loadMerged = {afOffset_r[OW-1:SL], writeData};
      `DCFIFO_STEP_AF_HI: loadMerged = {writeData, afOffset_r[SL-1:0]};
      default:            loadMerged = {OW{1'b0}};
    endcase
  end

  // Offset register: bits above the pointer width are masked, so any value
  // from 0 to depth-1 can be set, one word apart
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      aeOffset_r <= AE_RESET;
      afOffset_r <= AF_RESET;
      loadStep_r <= `DCFIFO_STEP_AE_LO;
    end
    else if (!masterResetN)
    begin
      aeOffset_r <= AE_RESET;
      afOffset_r <= AF_RESET;
      loadStep_r <= `DCFIFO_STEP_AE_LO;
    end
    else if (offLoad)
    begin
      if (!loadStep_r[1])
      begin
        aeOffset_r <= loadMerged & OFF_MASK;
      end
      else
      begin
        afOffset_r <= loadMerged & OFF_MASK;
      end
      loadStep_r <= loadStepNxt;
    end
  end

  // Slice of the offset register shown on an offset read
  always @*
  begin
    offSlice = {WIDTH{1'b0}};
    case (readStep_r)
      `DCFIFO_STEP_AE_LO: offSlice = aeOffset_r[SL-1:0];
      `DCFIFO_STEP_AE_HI: offSlice = aeOffset_r[OW-1:SL];
      `DCFIFO_STEP_AF_LO: offSlice = afOffset_r[SL-1:0];
      `DCFIFO_STEP_AF_HI: offSlice = afOffset_r[OW-1:SL];
      default:            offSlice = {WIDTH{1'b0}};
    endcase
  end

  // Output word: buffer data or offset slice, held between reads
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      readData_r <= {WIDTH{1'b0}};
      readStep_r <= `DCFIFO_STEP_AE_LO;
    end
    else if (!masterResetN)
    begin
      readData_r <= {WIDTH{1'b0}};
      readStep_r <= `DCFIFO_STEP_AE_LO;
    end
    else if (bufRead)
    begin
      readData_r <= ramWord;
    end
    else if (offRead)
    begin
      readData_r <= offSlice;
      readStep_r <= readStepNxt;
    end
  end

  // Output drivers; the enable is combinational so release is immediate
  assign readData         = readData_r;
  assign readDataOe       = ~outputEnableN;
  assign emptyFlagN       = emptyFlagN_r;
  assign fullFlagN        = fullFlagN_r;
  assign almostEmptyFlagN = almostEmptyFlagN_r;
  assign almostFullFlagN  = almostFullFlagN_r;

endmodule // dcfifo_top

/* sim/dcfifo_top_monitor.sv */
`timescale 1ns/1ps

// Watches the pins of one buffer instance
module dcfifo_top_monitor #(
  parameter WIDTH = 9
) (
  // Clock and resets
  input logic             mclk,
  input logic             reset,
  input logic             masterResetN,
  // Port controls
  input logic             writeClock,
  input logic             readClock,
  input logic             readEnableAN,
  input logic             readEnableBN,
  input logic             secondWriteEnableOrLoad,
  input logic             outputEnableN,
  // Outputs
  input logic [WIDTH-1:0] readData,
  input logic             readDataOe,
  input logic             emptyFlagN,
  input logic             fullFlagN,
  input logic             almostEmptyFlagN,
  input logic             almostFullFlagN
);
  logic wPrev_r;
  logic rPrev_r;
  wire  wEvt = writeClock & ~wPrev_r;
  wire  rEvt = readClock & ~rPrev_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // Last port clock levels, so port edges are seen as the design sees them
  always @(posedge mclk or posedge reset)
    if (reset)
    begin
      wPrev_r <= 1'b0;
      rPrev_r <= 1'b0;
    end
    else
    begin
      wPrev_r <= writeClock;
      rPrev_r <= readClock;
    end

  // Flag domains: outside master reset a flag may only move on its own port edge
  a_full_stable: assert property (masterResetN && !wEvt |=> $stable({fullFlagN, almostFullFlagN}))
    else $error("full side flags moved without a write edge");
  a_empty_stable: assert property (masterResetN && !rEvt |=> $stable({emptyFlagN, almostEmptyFlagN}))
    else $error("empty side flags moved without a read edge");
  a_mreset_clears: assert property (!masterResetN |=> !emptyFlagN && !almostEmptyFlagN && fullFlagN && almostFullFlagN)
    else $error("master reset did not leave the buffer empty");
  a_oe_follows: assert property (readDataOe == !outputEnableN)
    else $error("output drive does not follow its enable");
  // Outside master reset the output word only moves on a read edge
  a_data_holds: assert property (masterResetN && !rEvt |=> $stable(readData))
    else $error("read data moved without a read edge");
  // Master reset clears the word on its own, so it is kept out of the antecedent
  a_empty_refused: assert property (masterResetN && rEvt && !emptyFlagN && secondWriteEnableOrLoad
    |=> masterResetN |-> $stable(readData))
    else $error("read from an empty buffer changed the data");
  // Full means no free space, which is always within the offset
  a_full_has_af: assert property (!fullFlagN |-> !almostFullFlagN)
    else $error("full without almost full");
  a_empty_has_ae: assert property (!emptyFlagN |-> !almostEmptyFlagN)
    else $error("empty without almost empty");

  // Main scenarios reached
  c_read: cover property (rEvt && emptyFlagN && !readEnableAN && !readEnableBN);
  c_full: cover property (!fullFlagN);
  c_offset_mode: cover property (!masterResetN && !secondWriteEnableOrLoad);
endmodule // dcfifo_top_monitor

/* sim/dcfifo_port_agent.sv */
`timescale 1ns/1ps

// Writing and reading agents: free-running port clocks
module dcfifo_port_agent (
  // System clock and reset
  input  logic mclk,
  input  logic reset,
  // Port clocks
  output logic writeClock,
  output logic readClock
);
  logic portClk_r;

  // Half a port period per system cycle, so each high has a low before it
  always @(posedge mclk or posedge reset)
    if (reset)
      portClk_r <= 1'b0;
    else
      portClk_r <= ~portClk_r;

  // One source feeds both ports: the tied single-clock wiring
  assign writeClock = portClk_r;
  assign readClock  = portClk_r;
endmodule // dcfifo_port_agent

/* sim/test_dcfifo_top.sv */
`timescale 1ns/1ps

module test_dcfifo_top;
  localparam int DEPTH = 64;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       masterResetN = 1'b1;
  logic       primaryWriteEnableN = 1'b1;
  logic       secondWriteEnableOrLoad = 1'b1;
  logic [8:0] writeData = 9'h000;
  logic       readEnableAN = 1'b1;
  logic       readEnableBN = 1'b1;
  logic       outputEnableN = 1'b0;
  wire        writeClock;
  wire        readClock;
  wire  [8:0] readData;
  wire        readDataOe;
  wire        emptyFlagN;
  wire        fullFlagN;
  wire        almostEmptyFlagN;
  wire        almostFullFlagN;
  int         err_total = 0;
  int         comparisons = 0;

  // 10 MHz system clock
  always #50 mclk = ~mclk;

  dcfifo_port_agent u_dcfifo_port_agent (.mclk(mclk), .reset(reset),
    .writeClock(writeClock), .readClock(readClock));

  // Small depth keeps the fill short
  dcfifo_top #(.WIDTH(9), .DEPTH(DEPTH), .AW(6)) u_dcfifo_top (.mclk(mclk), .reset(reset),
    .masterResetN(masterResetN), .writeClock(writeClock),
    .primaryWriteEnableN(primaryWriteEnableN), .secondWriteEnableOrLoad(secondWriteEnableOrLoad),
    .writeData(writeData), .readClock(readClock), .readEnableAN(readEnableAN),
    .readEnableBN(readEnableBN), .outputEnableN(outputEnableN), .readData(readData),
    .readDataOe(readDataOe), .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN),
    .almostEmptyFlagN(almostEmptyFlagN), .almostFullFlagN(almostFullFlagN));

  task automatic wrap_up;
    $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chkData(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  // Flags packed as empty, almost empty, almost full, full
  task automatic chkFlags(input logic [3:0] exp);
    comparisons++;
    if ({emptyFlagN, almostEmptyFlagN, almostFullFlagN, fullFlagN} !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: flags %h expected %h", $time,
        {emptyFlagN, almostEmptyFlagN, almostFullFlagN, fullFlagN}, exp);
    end
  endtask

  // Stop at a system edge with the port clock low; the next edge is a port edge
  task automatic syncLow;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (writeClock !== 1'b0 && n < 4);
    if (writeClock !== 1'b0)
    begin
      err_total++;
      wrap_up();
    end
  endtask

  // At least one port edge on the tied port clocks, so both flag domains have been refreshed
  task automatic settle;
    syncLow();
    syncLow();
  endtask

  // Enable held across exactly one write edge; consecutive calls hit every edge
  task automatic pushWord(input logic [8:0] d, input logic en2);
    syncLow();
    primaryWriteEnableN     <= 1'b0;
    secondWriteEnableOrLoad <= en2; // Steered as expansion logic would
    writeData               <= d;
    @(posedge mclk);
    primaryWriteEnableN     <= 1'b1;
  endtask

  task automatic popWord(input logic [8:0] exp);
    syncLow();
    readEnableAN <= 1'b0;
    readEnableBN <= 1'b0;
    @(posedge mclk);
    readEnableAN <= 1'b1;
    readEnableBN <= 1'b1;
    @(posedge mclk);
    chkData(readData, exp);
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    settle();
    chkFlags(4'b0011);
    pushWord(9'h155, 1'b0);
    settle();
    chkFlags(4'b0011);
    $display("test reset and enable two done");
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7)
      begin
        settle();
        chkFlags(4'b1011);
      end
      pushWord(9'h1F0 + 9'(i), 1'b1);
    end
    settle();
    chkFlags(4'b1111);
    for (int i = 0; i < 8; i++)
      popWord(9'h1F0 + 9'(i));
    settle();
    chkFlags(4'b0011);
    popWord(9'h1F7);
    $display("test order and empty done");
    for (int i = 0; i < DEPTH; i++)
    begin
      if (i == DEPTH - 8 || i == DEPTH - 7)
      begin
        settle();
        chkFlags((i == DEPTH - 7) ? 4'b1101 : 4'b1111);
      end
      pushWord(9'(i * 7), 1'b1);
    end
    settle();
    chkFlags(4'b1100);
    pushWord(9'h0AA, 1'b1);
    settle();
    chkFlags(4'b1100);
    for (int i = 0; i < DEPTH; i++)
      popWord(9'(i * 7));
    settle();
    chkFlags(4'b0011);
    $display("test fill and overflow done");
    // Strap low held through master reset selects offset access
    secondWriteEnableOrLoad <= 1'b0;
    masterResetN            <= 1'b0;
    settle();
    masterResetN            <= 1'b1;
    settle();
    chkFlags(4'b0011);
    pushWord(9'h002, 1'b0);
    pushWord(9'h003, 1'b0);
    popWord(9'h002);
    popWord(9'h003);
    pushWord(9'h011, 1'b1);
    pushWord(9'h012, 1'b1);
    outputEnableN <= 1'b1;
    settle();
    chkFlags(4'b1011);
    outputEnableN <= 1'b0;
    pushWord(9'h013, 1'b1);
    settle();
    chkFlags(4'b1111);
    popWord(9'h011);
    $display("test offset mode done");
    wrap_up();
  end
endmodule // test_dcfifo_top

bind dcfifo_top dcfifo_top_monitor #(.WIDTH(WIDTH)) u_dcfifo_top_monitor (.mclk(mclk),
  .reset(reset), .masterResetN(masterResetN), .writeClock(writeClock),
  .readClock(readClock), .readEnableAN(readEnableAN), .readEnableBN(readEnableBN),
  .secondWriteEnableOrLoad(secondWriteEnableOrLoad), .outputEnableN(outputEnableN),
  .readData(readData), .readDataOe(readDataOe), .emptyFlagN(emptyFlagN),
  .fullFlagN(fullFlagN), .almostEmptyFlagN(almostEmptyFlagN),
  .almostFullFlagN(almostFullFlagN));
